// ==== sim/tb_top.sv ====
`default_nettype none
module tb_top
	import wex_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst, protection_lock, lock_req, break_req;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, timer_update, fault_state;
	logic timer_lock_update_flag, on_chip_debugger_break;
	logic [1:0] s_axi_bresp;
	logic [3:0] waveform_generator_output, wave_req;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [7:0] fault_events, event_req;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	wex_port_s port_ctl;
	int mismatches = 0, compares = 0;
	wex_waveform_ext dut (
		.sys_clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp(), .s_axi_rvalid, .s_axi_rready,
		.waveform_generator_output, .timer_update, .timer_lock_update_flag,
		.fault_events, .on_chip_debugger_break, .protection_lock,
		.port_ctl, .fault_state
	);
	wex_timer_model u_tmr (
		.sys_clk, .rst, .wave_req, .lock_req, .event_req, .break_req,
		.waveform_generator_output, .timer_update, .timer_lock_update_flag,
		.fault_events, .on_chip_debugger_break
	);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#100us;
		mismatches++;
		end_of_test();
	end
	// ==========
	// shared tasks
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic at(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic wait_upd();
		int n;
		n = 0;
		repeat (2) @(posedge sys_clk);
		do @(negedge sys_clk);
		while (!timer_update && n++ < 100);
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		logic aw, w, b;
		int n;
		b = 1'b0;
		n = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h00_0000, d};
		{s_axi_awvalid, s_axi_wvalid} <= 2'h3;
		while (!b && n++ < 50) begin
			@(negedge sys_clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid && s_axi_bready;
			@(posedge sys_clk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
			if (b)
				s_axi_bready <= 1'b0;
			else if (!s_axi_awvalid && !s_axi_wvalid)
				s_axi_bready <= 1'b1;
		end
		if (!b) begin
			mismatches++;
			$display("Error write %h expected response seen none", idx);
		end
	endtask
	task automatic rchk(input logic [3:0] idx, input logic [7:0] e);
		logic a, r;
		logic [7:0] d;
		int n;
		r = 1'b0;
		n = 0;
		@(posedge sys_clk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		while (!r && n++ < 50) begin
			@(negedge sys_clk);
			a = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid && s_axi_rready;
			if (r)
				d = s_axi_rdata[7:0];
			@(posedge sys_clk);
			if (a)
				s_axi_arvalid <= 1'b0;
			if (r)
				s_axi_rready <= 1'b0;
			else if (!s_axi_arvalid)
				s_axi_rready <= 1'b1;
		end
		chk($sformatf("reg %h", idx), e, d);
	endtask
	// ==========
	// tests
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, protection_lock, lock_req, break_req} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, wave_req, event_req} = 24'h00_0000;
		s_axi_wdata = 32'h0000_0000;
		rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rchk(IDX_STATUS, 8'h00);
		wr(IDX_WAVE_CTRL, 8'hff);
		rchk(IDX_WAVE_CTRL, 8'h3f);
		wr(IDX_FAULT_CTRL, 8'hff);
		rchk(IDX_FAULT_CTRL, 8'h17);
		wr(IDX_FAULT_CTRL, 8'h00);
		wr(4'h5, 8'hff);
		rchk(4'h5, 8'h00);
		rchk(4'hf, 8'h00);
		wr(IDX_STATUS, 8'hff);
		rchk(IDX_STATUS, 8'h00);
		$display("test map done");
		wr(IDX_DT_BOTH, 8'h5a);
		rchk(IDX_DT_LOW, 8'h5a);
		rchk(IDX_DT_HIGH, 8'h5a);
		rchk(IDX_DT_BOTH, 8'h00);
		lock_req <= 1'b1;
		wr(IDX_DT_BOTH_BUF, 8'h04);
		rchk(IDX_DT_LOW_BUF, 8'h04);
		rchk(IDX_DT_HIGH_BUF, 8'h04);
		rchk(IDX_STATUS, 8'h03);
		wait_upd();
		rchk(IDX_DT_LOW, 8'h5a);
		lock_req <= 1'b0;
		wait_upd();
		rchk(IDX_DT_LOW, 8'h04);
		rchk(IDX_STATUS, 8'h00);
		wr(IDX_DT_HIGH_BUF, 8'h06);
		rchk(IDX_STATUS, 8'h02);
		wait_upd();
		rchk(IDX_DT_HIGH, 8'h06);
		$display("test buffers done");
		wr(IDX_DT_LOW, 8'h08);
		wr(IDX_DT_HIGH, 8'h18);
		wr(IDX_WAVE_CTRL, 8'h01);
		wave_req <= 4'h1;
		at(2);
		chk("pins a", 8'h00, port_ctl.pin_out & 8'h03);
		at(14);
		chk("pins a", 8'h01, port_ctl.pin_out & 8'h03);
		@(posedge sys_clk);
		wave_req <= 4'h0;
		at(2);
		chk("pins a", 8'h00, port_ctl.pin_out & 8'h03);
		at(30);
		chk("pins a", 8'h02, port_ctl.pin_out & 8'h03);
		wr(IDX_WAVE_CTRL, 8'h12);
		wave_req <= 4'h1;
		at(16);
		chk("pins b", 8'h04, port_ctl.pin_out & 8'h0c);
		wr(IDX_OVERRIDE, 8'hff);
		wr(IDX_WAVE_CTRL, 8'h21);
		at(2);
		chk("pins", 8'hff, port_ctl.pin_out);
		chk("override", 8'hff, port_ctl.pin_override);
		chk("dir", 8'h00, port_ctl.dir_clear);
		@(posedge sys_clk);
		wave_req <= 4'h0;
		at(3);
		chk("pins", 8'h00, port_ctl.pin_out);
		wr(IDX_WAVE_CTRL, 8'h00);
		$display("test waveforms done");
		wr(IDX_FAULT_MASK, 8'h01);
		wr(IDX_FAULT_CTRL, 8'h01);
		event_req <= 8'h01;
		at(2);
		chk("fault", 8'h01, {7'h00, fault_state});
		chk("override", 8'h00, port_ctl.pin_override);
		rchk(IDX_STATUS, 8'h04);
		rchk(IDX_OVERRIDE, 8'h00);
		wr(IDX_OVERRIDE, 8'h0f);
		rchk(IDX_OVERRIDE, 8'h00);
		event_req <= 8'h00;
		wait_upd();
		wait_upd();
		at(0);
		chk("fault", 8'h01, {7'h00, fault_state});
		wr(IDX_STATUS, 8'h00);
		rchk(IDX_STATUS, 8'h04);
		wr(IDX_STATUS, 8'h04);
		rchk(IDX_STATUS, 8'h00);
		wait_upd();
		at(0);
		chk("fault", 8'h00, {7'h00, fault_state});
		wr(IDX_OVERRIDE, 8'h0f);
		rchk(IDX_OVERRIDE, 8'h0f);
		$display("test latched done");
		wr(IDX_WAVE_CTRL, 8'h01);
		wr(IDX_FAULT_MASK, 8'h80);
		wr(IDX_FAULT_CTRL, 8'h07);
		event_req <= 8'h01;
		at(4);
		chk("fault", 8'h00, {7'h00, fault_state});
		@(posedge sys_clk);
		event_req <= 8'h81;
		at(2);
		chk("fault", 8'h01, {7'h00, fault_state});
		chk("dir", 8'h03, port_ctl.dir_clear);
		@(posedge sys_clk);
		event_req <= 8'h00;
		wait_upd();
		at(0);
		chk("fault", 8'h00, {7'h00, fault_state});
		rchk(IDX_STATUS, 8'h04);
		wr(IDX_STATUS, 8'h04);
		wr(IDX_FAULT_CTRL, 8'h06);
		event_req <= 8'h80;
		at(4);
		chk("fault", 8'h00, {7'h00, fault_state});
		rchk(IDX_STATUS, 8'h00);
		event_req <= 8'h00;
		wr(IDX_FAULT_CTRL, 8'h15);
		break_req <= 1'b1;
		at(4);
		chk("fault", 8'h00, {7'h00, fault_state});
		wr(IDX_FAULT_CTRL, 8'h05);
		at(2);
		chk("fault", 8'h01, {7'h00, fault_state});
		@(posedge sys_clk);
		break_req <= 1'b0;
		wait_upd();
		at(0);
		chk("fault", 8'h00, {7'h00, fault_state});
		rchk(IDX_OVERRIDE, 8'h03);
		wr(IDX_STATUS, 8'h04);
		$display("test cycle done");
		wr(IDX_OVERRIDE, 8'h3c);
		protection_lock <= 1'b1;
		wr(IDX_WAVE_CTRL, 8'h12);
		rchk(IDX_WAVE_CTRL, 8'h01);
		wr(IDX_FAULT_MASK, 8'h00);
		rchk(IDX_FAULT_MASK, 8'h80);
		wr(IDX_OVERRIDE, 8'h00);
		rchk(IDX_OVERRIDE, 8'h3c);
		wr(IDX_FAULT_CTRL, 8'h00);
		rchk(IDX_FAULT_CTRL, 8'h00);
		protection_lock <= 1'b0;
		$display("test lock done");
		end_of_test();
	end
endmodule
`default_nettype wire

// ==== sim/wex_checker_assertions.sv ====
`default_nettype none
module wex_checker
	import wex_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// timer and port
	input wire logic timer_update,
	input wire wex_port_s port_ctl,
	input wire logic fault_state
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// ==========
	// bus answers
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("bvalid dropped early");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready &&
		!s_axi_wready && s_axi_bresp == RESP_OKAY) else $error("write busy");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read not answered");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready while rvalid");
	a_rdata_narrow: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000 &&
		s_axi_rresp == RESP_OKAY)
		else $error("read upper data or response wrong");
	// ==========
	// fault behaviour, dead-time gap and covers
	a_dir_in_fault: assert property (
		!fault_state |-> port_ctl.dir_clear == 8'h00)
		else $error("direction cleared outside fault");
	a_exit_on_update: assert property (
		$fell(fault_state) |-> $past(timer_update))
		else $error("fault left without update");
	a_dead_gap: assert property (
		port_ctl.pin_out[0] != port_ctl.pin_out[1] |=>
		port_ctl.pin_out[1:0] != ~$past(port_ctl.pin_out[1:0]))
		else $error("pin pair swapped without dead time");
	c_fault: cover property ($rose(fault_state));
	c_dir: cover property (port_ctl.dir_clear != 8'h00);
	c_bstall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind wex_waveform_ext wex_checker u_chk (
	.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .timer_update, .port_ctl, .fault_state
);
`default_nettype wire

// ==== sim/wex_timer_model.sv ====
`default_nettype none
module wex_timer_model #(
	parameter int PERIOD = 16
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// bench requests
	input wire logic [3:0] wave_req,
	input wire logic lock_req,
	input wire logic [7:0] event_req,
	input wire logic break_req,
	// timer, event and debugger side
	output logic [3:0] waveform_generator_output,
	output logic timer_update,
	output logic timer_lock_update_flag,
	output logic [7:0] fault_events,
	output logic on_chip_debugger_break
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;
	// ==========
	// free-running period, update pulse once per wrap
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt <= 8'h00;
			timer_update <= 1'b0;
			waveform_generator_output <= 4'h0;
			{timer_lock_update_flag, on_chip_debugger_break} <= 2'h0;
			fault_events <= 8'h00;
		end else begin
			cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
			timer_update <= cnt == 8'(PERIOD - 1);
			waveform_generator_output <= wave_req;
			{timer_lock_update_flag, on_chip_debugger_break} <=
				{lock_req, break_req};
			fault_events <= event_req;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/wex_pkg.sv ====
`default_nettype none
package wex_pkg;
	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_WAVE_CTRL = 4'h0;
	localparam logic [3:0] IDX_FAULT_MASK = 4'h2;
	localparam logic [3:0] IDX_FAULT_CTRL = 4'h3;
	localparam logic [3:0] IDX_STATUS = 4'h4;
	localparam logic [3:0] IDX_DT_BOTH = 4'h6;
	localparam logic [3:0] IDX_DT_BOTH_BUF = 4'h7;
	localparam logic [3:0] IDX_DT_LOW = 4'h8;
	localparam logic [3:0] IDX_DT_HIGH = 4'h9;
	localparam logic [3:0] IDX_DT_LOW_BUF = 4'ha;
	localparam logic [3:0] IDX_DT_HIGH_BUF = 4'hb;
	localparam logic [3:0] IDX_OVERRIDE = 4'hc;
	localparam int ADDR_LSB = 2;

	// status register bit positions
	localparam int ST_LOW_VALID = 0;
	localparam int ST_HIGH_VALID = 1;
	localparam int ST_FAULT_FLAG = 2;

	// fault action codes
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_CLEAR_OVERRIDES = 2'h1;
	localparam logic [1:0] ACT_UNDEFINED = 2'h2;
	localparam logic [1:0] ACT_CLEAR_DIRECTIONS = 2'h3;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;

	typedef struct packed {
		logic [1:0] rsvd;
		logic pattern_mode_bit;
		logic common_waveform_bit;
		logic [3:0] channel_dead_time_enables;
	} wex_ctrl_s;

	typedef struct packed {
		logic [2:0] rsvd_hi;
		logic debug_break_ignore_bit;
		logic rsvd_lo;
		logic restart_mode_bit;
		logic [1:0] fault_action_field;
	} wex_fault_ctrl_s;

	typedef struct packed {
		logic [7:0] pin_out;
		logic [7:0] pin_override;
		logic [7:0] dir_clear;
	} wex_port_s;
endpackage
`default_nettype wire

// ==== verilog/wex_waveform_ext.sv ====
// Functional notes
// - pattern mode bit overrides dead time; dead-time registers hold the pattern.
// - common waveform bit feeds channel A into all four generators.
// - per-channel enable puts dead-time output on that channel's pin pair.
// - masked event channels are ORed into one fault condition.
// - a detected fault sets the fault flag and performs the selected action.
// - fault flag clears only on a written one.
// - debug break counts as fault unless the ignore bit is set.
// - restart mode bit: zero latched, one cycle-by-cycle.
// - latched: leave fault at update once fault gone and flag cleared.
// - cycle-by-cycle: leave fault at first update once fault gone.
// - action 00 none, 01 clears overrides, 11 clears dead-time pin directions.
// - buffer write sets valid; update copies valid buffer to working register.
// - buffer copy suppressed while timer lock update flag is set.
// - combined location writes both working dead-time registers at once.
// - combined buffer location writes both buffers at once.
// - working dead-time registers hold eight-bit clock-cycle counts.
// - override register writes ignored while fault flag is set.
// - override bits override pin outputs one-to-one, never directions.
// - upper five status bits read zero.
// - per-channel counter reloads on edges, counts down, blanks outputs.
// - fault action takes effect within two clocks of the event.
// - pattern mode drives overridden pins from channel A waveform.
// - protection lock blocks writes to waveform control, override and mask; fault control stays writable.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`default_nettype none
module wex_waveform_ext
	import wex_pkg::*;
#(
	parameter int ADDR_W = 6,
	parameter int CHANNELS = 4,
	parameter int EVENT_CHANNELS = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// timer side
	input wire logic [CHANNELS-1:0] waveform_generator_output,
	input wire logic timer_update,
	input wire logic timer_lock_update_flag,
	// event system, debugger and protection lock
	input wire logic [EVENT_CHANNELS-1:0] fault_events,
	input wire logic on_chip_debugger_break,
	input wire logic protection_lock,
	// port side
	output wex_port_s port_ctl,
	output logic fault_state
);
	// ============================================================
	// register state
	wex_ctrl_s ctrl, next_ctrl;
	wex_fault_ctrl_s fctrl, next_fctrl;
	logic [7:0] fault_event_mask_bits, next_fault_event_mask_bits;
	logic [7:0] dt_low, next_dt_low;
	logic [7:0] dt_high, next_dt_high;
	logic [7:0] dt_low_buf, next_dt_low_buf;
	logic [7:0] dt_high_buf, next_dt_high_buf;
	logic [7:0] per_pin_override_enable, next_per_pin_override_enable;
	logic low_side_buffer_valid, next_low_side_buffer_valid;
	logic high_side_buffer_valid, next_high_side_buffer_valid;
	logic fault_detect_flag, next_fault_detect_flag;
	logic fault_held, next_fault_held;
	logic restore_pending, next_restore_pending;

	// ============================================================
	// bus slave state
	logic aw_full, next_aw_full;
	logic w_full, next_w_full;
	logic [3:0] aw_idx, next_aw_idx;
	logic [7:0] w_byte, next_w_byte;
	logic w_lane0, next_w_lane0;
	logic bvalid, next_bvalid;
	logic rvalid, next_rvalid;
	logic [31:0] rdata, next_rdata;

	logic do_write;
	logic [7:0] status_byte;
	logic [7:0] read_byte;
	logic [3:0] ar_idx;

	assign s_axi_awready = !aw_full && !bvalid;
	assign s_axi_wready = !w_full && !bvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = RESP_OKAY;
	assign s_axi_arready = !rvalid;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = RESP_OKAY;
	assign do_write = aw_full && w_full && !bvalid;
	assign ar_idx = s_axi_araddr[ADDR_LSB+3:ADDR_LSB];

	assign status_byte = {5'h00, fault_detect_flag, high_side_buffer_valid,
		low_side_buffer_valid};

	// ============================================================
	// fault detection
	logic fault_enabled;
	logic event_hit;
	logic fault_now;
	logic fault_active;
	logic update_ok;
	logic release_ok;

	// codes 00 and 10 both leave protection off
	assign fault_enabled = fctrl.fault_action_field[0];
	assign event_hit = |(fault_events & fault_event_mask_bits);
	assign fault_now = fault_enabled && (event_hit ||
		(on_chip_debugger_break && !fctrl.debug_break_ignore_bit));
	// the action acts in the event's own cycle, well inside two clocks
	assign fault_active = fault_now || fault_held;
	assign fault_state = fault_active;
	assign update_ok = timer_update && !timer_lock_update_flag;
	// the update at which a held fault ends, so restore lands on the same one
	assign release_ok = update_ok && !fault_now &&
		(!fault_held || fctrl.restart_mode_bit || !fault_detect_flag);

	// ============================================================
	// bus slave and register file
	always_comb begin
		case (ar_idx)
			IDX_WAVE_CTRL: read_byte = ctrl;
			IDX_FAULT_MASK: read_byte = fault_event_mask_bits;
			IDX_FAULT_CTRL: read_byte = fctrl;
			IDX_STATUS: read_byte = status_byte;
			IDX_DT_LOW: read_byte = dt_low;
			IDX_DT_HIGH: read_byte = dt_high;
			IDX_DT_LOW_BUF: read_byte = dt_low_buf;
			IDX_DT_HIGH_BUF: read_byte = dt_high_buf;
			IDX_OVERRIDE: read_byte = per_pin_override_enable;
			default: read_byte = RESET_BYTE;
		endcase
	end

	always_comb begin
		next_aw_full = aw_full;
		next_w_full = w_full;
		next_aw_idx = aw_idx;
		next_w_byte = w_byte;
		next_w_lane0 = w_lane0;
		next_bvalid = bvalid;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_ctrl = ctrl;
		next_fctrl = fctrl;
		next_fault_event_mask_bits = fault_event_mask_bits;
		next_dt_low = dt_low;
		next_dt_high = dt_high;
		next_dt_low_buf = dt_low_buf;
		next_dt_high_buf = dt_high_buf;
		next_per_pin_override_enable = per_pin_override_enable;
		next_low_side_buffer_valid = low_side_buffer_valid;
		next_high_side_buffer_valid = high_side_buffer_valid;
		next_fault_detect_flag = fault_detect_flag;
		next_fault_held = fault_held;
		next_restore_pending = restore_pending;

		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_full = 1'b1;
			next_aw_idx = s_axi_awaddr[ADDR_LSB+3:ADDR_LSB];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_full = 1'b1;
			next_w_byte = s_axi_wdata[7:0];
			next_w_lane0 = s_axi_wstrb[0];
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rdata = {24'h00_0000, read_byte};
		end

		// buffer copy at the timer update
		if (update_ok) begin
			if (low_side_buffer_valid) begin
				next_dt_low = dt_low_buf;
				next_low_side_buffer_valid = 1'b0;
			end
			if (high_side_buffer_valid) begin
				next_dt_high = dt_high_buf;
				next_high_side_buffer_valid = 1'b0;
			end
		end

		// overrides come back at the update that ends the fault
		if (restore_pending && release_ok) begin
			next_restore_pending = 1'b0;
			if (ctrl.pattern_mode_bit) begin
				next_per_pin_override_enable = dt_low_buf;
			end else begin
				for (int c = 0; c < CHANNELS; c++) begin
					next_per_pin_override_enable[2*c] =
						ctrl.channel_dead_time_enables[c];
					next_per_pin_override_enable[2*c+1] =
						ctrl.channel_dead_time_enables[c];
				end
			end
		end

		if (do_write) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			if (w_lane0) begin
				case (aw_idx)
					IDX_WAVE_CTRL: begin
						if (!protection_lock) begin
							next_ctrl = w_byte;
							next_ctrl.rsvd = 2'h0;
						end
					end
					IDX_FAULT_MASK: begin
						if (!protection_lock) begin
							next_fault_event_mask_bits = w_byte;
						end
					end
					IDX_FAULT_CTRL: begin
						next_fctrl = w_byte;
						next_fctrl.rsvd_hi = 3'h0;
						next_fctrl.rsvd_lo = 1'b0;
					end
					IDX_STATUS: begin
						if (w_byte[ST_FAULT_FLAG]) begin
							next_fault_detect_flag = 1'b0;
						end
					end
					IDX_DT_BOTH: begin
						next_dt_low = w_byte;
						next_dt_high = w_byte;
					end
					IDX_DT_BOTH_BUF: begin
						next_dt_low_buf = w_byte;
						next_dt_high_buf = w_byte;
						next_low_side_buffer_valid = 1'b1;
						next_high_side_buffer_valid = 1'b1;
					end
					IDX_DT_LOW: next_dt_low = w_byte;
					IDX_DT_HIGH: next_dt_high = w_byte;
					IDX_DT_LOW_BUF: begin
						next_dt_low_buf = w_byte;
						next_low_side_buffer_valid = 1'b1;
					end
					IDX_DT_HIGH_BUF: begin
						next_dt_high_buf = w_byte;
						next_high_side_buffer_valid = 1'b1;
					end
					IDX_OVERRIDE: begin
						if (!protection_lock && !fault_detect_flag) begin
							next_per_pin_override_enable = w_byte;
						end
					end
					default: begin
					end
				endcase
			end
		end

		// fault entry and exit; a new fault beats a clear in one cycle
		if (fault_now) begin
			next_fault_detect_flag = 1'b1;
			next_fault_held = 1'b1;
			if (fctrl.fault_action_field == ACT_CLEAR_OVERRIDES) begin
				next_per_pin_override_enable = RESET_BYTE;
				next_restore_pending = 1'b1;
			end
		end else if (fault_held && update_ok) begin
			if (fctrl.restart_mode_bit) begin
				next_fault_held = 1'b0;
			end else if (!fault_detect_flag) begin
				next_fault_held = 1'b0;
			end
		end
		if (!fault_enabled) begin
			next_fault_held = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_idx <= IDX_WAVE_CTRL;
			w_byte <= RESET_BYTE;
			w_lane0 <= 1'b0;
			bvalid <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			ctrl <= RESET_BYTE;
			fctrl <= RESET_BYTE;
			fault_event_mask_bits <= RESET_BYTE;
			dt_low <= RESET_BYTE;
			dt_high <= RESET_BYTE;
			dt_low_buf <= RESET_BYTE;
			dt_high_buf <= RESET_BYTE;
			per_pin_override_enable <= RESET_BYTE;
			low_side_buffer_valid <= 1'b0;
			high_side_buffer_valid <= 1'b0;
			fault_detect_flag <= 1'b0;
			fault_held <= 1'b0;
			restore_pending <= 1'b0;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			aw_idx <= next_aw_idx;
			w_byte <= next_w_byte;
			w_lane0 <= next_w_lane0;
			bvalid <= next_bvalid;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			ctrl <= next_ctrl;
			fctrl <= next_fctrl;
			fault_event_mask_bits <= next_fault_event_mask_bits;
			dt_low <= next_dt_low;
			dt_high <= next_dt_high;
			dt_low_buf <= next_dt_low_buf;
			dt_high_buf <= next_dt_high_buf;
			per_pin_override_enable <= next_per_pin_override_enable;
			low_side_buffer_valid <= next_low_side_buffer_valid;
			high_side_buffer_valid <= next_high_side_buffer_valid;
			fault_detect_flag <= next_fault_detect_flag;
			fault_held <= next_fault_held;
			restore_pending <= next_restore_pending;
		end
	end

	// ============================================================
	// dead-time generators
	logic [CHANNELS-1:0] wave_sel;
	logic [CHANNELS-1:0] wave_prev, next_wave_prev;
	logic [7:0] dt_cnt [CHANNELS];
	logic [7:0] next_dt_cnt [CHANNELS];
	logic [CHANNELS-1:0] side_low;
	logic [CHANNELS-1:0] side_high;

	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			wave_sel[c] = ctrl.common_waveform_bit ?
				waveform_generator_output[0] :
				waveform_generator_output[c];
			next_wave_prev[c] = wave_sel[c];
			if (wave_sel[c] && !wave_prev[c]) begin
				next_dt_cnt[c] = dt_low;
			end else if (!wave_sel[c] && wave_prev[c]) begin
				next_dt_cnt[c] = dt_high;
			end else if (dt_cnt[c] != 8'h00) begin
				next_dt_cnt[c] = dt_cnt[c] - 8'h01;
			end else begin
				next_dt_cnt[c] = dt_cnt[c];
			end
			// with a nonzero dead time the edge cycle is already dead, so the pair does not swap at once; a zero dead time swaps it at once
			side_low[c] = wave_sel[c] && (next_dt_cnt[c] == 8'h00);
			side_high[c] = !wave_sel[c] && (next_dt_cnt[c] == 8'h00);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wave_prev <= '0;
			for (int c = 0; c < CHANNELS; c++) begin
				dt_cnt[c] <= RESET_BYTE;
			end
		end else begin
			wave_prev <= next_wave_prev;
			for (int c = 0; c < CHANNELS; c++) begin
				dt_cnt[c] <= next_dt_cnt[c];
			end
		end
	end

	// ============================================================
	// port output mux; pins 2c and 2c+1 are channel c low and high side
	logic [7:0] next_pin_out;
	logic [7:0] pair_mask;
	logic [7:0] pin_out_q;
	logic clear_overrides;

	assign clear_overrides = fault_active &&
		(fctrl.fault_action_field == ACT_CLEAR_OVERRIDES);

	always_comb begin
		pair_mask = 8'h00;
		next_pin_out = 8'h00;
		for (int c = 0; c < CHANNELS; c++) begin
			pair_mask[2*c] = ctrl.channel_dead_time_enables[c];
			pair_mask[2*c+1] = ctrl.channel_dead_time_enables[c];
			next_pin_out[2*c] = side_low[c];
			next_pin_out[2*c+1] = side_high[c];
		end
		if (ctrl.pattern_mode_bit) begin
			next_pin_out = {8{waveform_generator_output[0]}};
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin_out_q <= RESET_BYTE;
		end else begin
			pin_out_q <= next_pin_out;
		end
	end

	assign port_ctl.pin_out = pin_out_q;
	// pattern mode takes every overridden pin, dead time only its pairs
	assign port_ctl.pin_override = clear_overrides ? 8'h00 :
		per_pin_override_enable &
		(ctrl.pattern_mode_bit ? 8'hff : pair_mask);
	assign port_ctl.dir_clear = (fault_active &&
		fctrl.fault_action_field == ACT_CLEAR_DIRECTIONS) ?
		(ctrl.pattern_mode_bit ? dt_low_buf : pair_mask) : 8'h00;

endmodule
`default_nettype wire
